/* File: rtl/sfcp_defines.svh */
// constants of the serial flash command framing and protection block
// Function
// [R01] complement bit inverts the selected protected region
// [R02] erase/program touching protected area is ignored
// [R03] every instruction starts with chip select falling
// [R04] first single-line byte is the opcode
// [R05] single line sampled on rising edge, MSB first
// [R06] quad mode opcode from first four-line byte
// [R07] quad mode moves one byte per two clocks
// [R08] opcode optionally followed by address, data, dummies
// [R09] instruction ends when chip select rises
// [R10] reads may end after any clocked bit
// [R11] writes need chip select rise on byte boundary
// [R12] while busy only status read is served
// [R13] plain region from block, top/bottom, granularity bits
// [R14] quad mode entry needs quad enable set
// [R15] protection checked over full range before starting
// [R16] chip select rise discards partial instruction
`ifndef SFCP_DEFINES_SVH
`define SFCP_DEFINES_SVH
// opcodes
`define SFCP_OP_WREN    8'h06
`define SFCP_OP_WRDI    8'h04
`define SFCP_OP_RDSR1   8'h05
`define SFCP_OP_RDSR2   8'h35
`define SFCP_OP_WRSR    8'h01
`define SFCP_OP_PROG    8'h02
`define SFCP_OP_ERS4K   8'h20
`define SFCP_OP_ERS32K  8'h52
`define SFCP_OP_ERS64K  8'hd8
`define SFCP_OP_CHIP1   8'hc7
`define SFCP_OP_CHIP2   8'h60
`define SFCP_OP_QUADON  8'h38
`define SFCP_OP_QUADOFF 8'hff
// least frame bytes per command class
`define SFCP_NB_PROG    3'd5
`define SFCP_NB_ERASE   3'd4
`define SFCP_NB_WRSR    3'd2
`define SFCP_NB_ONE     3'd1
// status bit positions and reset values
`define SFCP_QE_RESET   1'b0
`define SFCP_SR2_QE     1
`define SFCP_SR2_CMP    6
// 4KB sectors of the 8MB array
`define SFCP_SECT_LAST  11'h7ff
`define SFCP_BIG_BASE   11'h020
// host register offsets and command fields
`define SFCP_REG_CMD    5'h00
`define SFCP_REG_ADDR   5'h04
`define SFCP_REG_WDATA  5'h08
`define SFCP_REG_CTRL   5'h0c
`define SFCP_REG_RDATA  5'h10
`define SFCP_CMD_HASADR 8
`define SFCP_CMD_QUAD   9
// link timing in mclk cycles
`define SFCP_SCLK_HALF  3'd4
`define SFCP_CS_GAP     4'd8
`endif

/* File: rtl/sfcp_pkg.sv */
// types shared by both ends of the flash link
package sfcp_pkg;
  typedef logic [7:0] sfcp_byte_type;
  typedef enum logic [1:0] {HS_IDLE, HS_ARM, HS_SHIFT, HS_GAP} sfcp_hstate_type;
endpackage

/* File: rtl/sfcp_link_if.sv */
// four-wire / quad flash link between host and device
`timescale 1ns/1ps
interface sfcp_link_if;
  logic       csN;        // chip select, active low
  logic       sclk;       // serial clock from host
  logic [3:0] hostIoOut;
  logic [3:0] hostIoOe;
  logic [3:0] devIoOut;
  logic [3:0] devIoOe;
  logic [3:0] io;         // resolved line level
  // resolved level per line, pull-up when nobody drives
  for (genvar i = 0; i < 4; i++)
  begin : g_line
    assign io[i] = hostIoOe[i] ? hostIoOut[i] : (devIoOe[i] ? devIoOut[i] : 1'b1);
  end
  modport host (output csN, sclk, hostIoOut, hostIoOe, input io);
  modport dev (input csN, sclk, io, output devIoOut, devIoOe);
endinterface

/* File: rtl/sfcp_protect.sv */
// protected-region check of a sector range
`timescale 1ns/1ps
`include "sfcp_defines.svh"
module sfcp_protect (
  // protection bits
  input  logic        sec,
  input  logic        tb,
  input  logic [2:0]  bp,
  input  logic        cmp,
  // sector range of the command
  input  logic [10:0] lo,
  input  logic [10:0] hi,
  // result
  output logic        hit
);
  logic [10:0] size;
  logic [10:0] regLo;
  logic [10:0] regHi;
  logic        none;
  logic        all;
  // region size in 4KB sectors
  always_comb
  begin
    if (sec)
      case (bp)
        3'd1:    size = 11'd1;
        3'd2:    size = 11'd2;
        3'd3:    size = 11'd4;
        default: size = 11'd8;
      endcase
    else
      size = `SFCP_BIG_BASE << (bp - 3'd1); // [R13]
    regLo = tb ? 11'h000 : (11'h000 - size);
    regHi = tb ? (size - 11'd1) : `SFCP_SECT_LAST;
    none  = (bp == 3'd0);
    all   = (bp == 3'd7);
    // any overlap with a protected sector rejects the whole range
    if (!cmp)
      hit = all | (!none & !(hi < regLo || lo > regHi)); // [R13] [R02]
    else
      hit = none | (!all & (lo < regLo || hi > regHi)); // [R01] [R02]
  end
endmodule

/* File: rtl/sfcp_device.sv */
// flash end: frame decoder on the link clock, command gate on mclk
`timescale 1ns/1ps
`include "sfcp_defines.svh"
module sfcp_device (
  // link
  sfcp_link_if.dev          link,
  // array side
  input  logic              mclk,
  input  logic              reset,
  output logic              opStart,
  output sfcp_pkg::sfcp_byte_type opCode,
  output logic [23:0]       opAddr,
  output sfcp_pkg::sfcp_byte_type opData,
  input  logic              opDone,
  // status view
  output logic              busy,
  output logic              quadMode
);
  import sfcp_pkg::*;

  // ************************************************************
  // status held on mclk
  // ************************************************************
  logic       busy_r;
  logic       wel_r;
  logic       quad_r;
  logic       qe_r;
  logic       cmp_r;
  logic       sec_r;
  logic       tb_r;
  logic [2:0] bp_r;
  logic [7:0] sts1;
  logic [7:0] sts2;
  assign sts1 = {1'b0, sec_r, tb_r, bp_r, wel_r, busy_r};
  assign sts2 = {1'b0, cmp_r, 4'h0, qe_r, 1'b0};

  // ************************************************************
  // levels into the link domain
  // ************************************************************
  logic [17:0] toLink;
  logic [17:0] lnkS1;
  logic [17:0] lnkS2;
  assign toLink = {reset, quad_r, sts2, sts1};
  // two flops per bit; sclk runs free so these settle between frames
  for (genvar i = 0; i < 18; i++)
  begin : g_lsync
    always_ff @(posedge link.sclk)
    begin
      lnkS1[i] <= toLink[i];
      lnkS2[i] <= lnkS1[i];
    end
  end
  logic wide;
  logic lrst;
  assign wide = lnkS2[16];
  assign lrst = lnkS2[17];

  // ************************************************************
  // frame decoder on the link clock
  // ************************************************************
  logic [2:0] bitPos_r;
  logic [2:0] byteCnt_r;
  logic       started_r;
  logic [7:0] shift_r;
  logic [2:0] posNxt;
  logic       byteDone;
  logic [7:0] shNxt;
  logic [2:0] bytesNxt;
  // one bit per edge on one line, a nibble on four lines
  always_comb
  begin
    posNxt   = bitPos_r + (wide ? 3'd4 : 3'd1); // [R07]
    byteDone = (posNxt == 3'd0);
    shNxt    = wide ? {shift_r[3:0], link.io} : {shift_r[6:0], link.io[0]}; // [R05] [R06]
    bytesNxt = (byteDone && byteCnt_r != 3'd7) ? byteCnt_r + 3'd1 : byteCnt_r;
  end

  // counters cleared while chip select is high
  always_ff @(posedge link.sclk or posedge link.csN)
  begin
    if (link.csN)
    begin
      bitPos_r  <= 3'd0; // [R16] [R03]
      byteCnt_r <= 3'd0;
      started_r <= 1'b0;
    end
    else
    begin
      bitPos_r  <= posNxt;
      byteCnt_r <= bytesNxt;
      started_r <= 1'b1;
    end
  end

  always_ff @(posedge link.sclk)
  begin
    shift_r <= shNxt;
  end

  // registered reset; the host holds sclk low in reset, so the synced copy never arrives
  logic       linkRst_r;
  always_ff @(posedge mclk)
  begin
    linkRst_r <= reset;
  end

  // snapshot of the frame, stable while chip select is high
  logic       frameTog_r;
  sfcp_byte_type opc_r;
  logic [23:0] addr_r;
  sfcp_byte_type dat0_r;
  sfcp_byte_type dat1_r;
  logic       aligned_r;
  logic [2:0] bytes_r;
  // released one mclk after reset, well before the first sclk edge
  always_ff @(posedge link.sclk or posedge linkRst_r)
  begin
    if (linkRst_r || lrst)
    begin
      frameTog_r <= 1'b0;
      aligned_r  <= 1'b0;
      bytes_r    <= 3'd0;
      opc_r      <= 8'h00;
    end
    else if (!link.csN)
    begin
      if (!started_r)
        frameTog_r <= ~frameTog_r; // [R03]
      aligned_r <= byteDone; // [R11]
      bytes_r   <= bytesNxt; // [R08]
      if (byteDone && byteCnt_r == 3'd0)
        opc_r <= shNxt; // [R04] [R06]
    end
  end

  // address and data fields by byte position
  always_ff @(posedge link.sclk)
  begin
    if (!link.csN && byteDone)
      case (byteCnt_r)
        3'd1:    addr_r[23:16] <= shNxt;
        3'd2:    addr_r[15:8]  <= shNxt;
        3'd3:    addr_r[7:0]   <= shNxt;
        3'd4:    dat0_r        <= shNxt;
        3'd5:    dat1_r        <= shNxt;
        default: ;
      endcase
  end

  // ************************************************************
  // status read-out
  // ************************************************************
  logic       rd_r;
  logic [7:0] out_r;
  logic       rdStart;
  // second status byte is refused while busy
  assign rdStart = byteDone && byteCnt_r == 3'd0 &&
                   (shNxt == `SFCP_OP_RDSR1 ||
                    (shNxt == `SFCP_OP_RDSR2 && !lnkS2[0])); // [R12]
  always_ff @(posedge link.sclk or posedge link.csN)
  begin
    if (link.csN)
      rd_r <= 1'b0; // [R10]
    else if (rdStart)
      rd_r <= 1'b1;
  end

  // byte repeats until chip select rises; it is not refreshed mid-frame
  always_ff @(posedge link.sclk)
  begin
    if (rdStart)
      out_r <= (shNxt == `SFCP_OP_RDSR1) ? lnkS2[7:0] : lnkS2[15:8];
    else if (rd_r)
      out_r <= wide ? {out_r[3:0], out_r[7:4]} : {out_r[6:0], out_r[7]};
  end

  // lines change on the falling edge for the host's next rising edge
  always_ff @(negedge link.sclk or posedge link.csN)
  begin
    if (link.csN)
    begin
      link.devIoOe  <= 4'h0;
      link.devIoOut <= 4'h0;
    end
    else
    begin
      link.devIoOe  <= rd_r ? (wide ? 4'hf : 4'h2) : 4'h0;
      link.devIoOut <= wide ? out_r[7:4] : {2'b00, out_r[7], 1'b0};
    end
  end

  // ************************************************************
  // frame end seen on mclk
  // ************************************************************
  logic csS1;
  logic csS2;
  logic csS3;
  logic togS1;
  logic togS2;
  logic togSeen_r;
  logic frameEnd;
  always_ff @(posedge mclk)
  begin
    csS1  <= link.csN;
    csS2  <= csS1;
    csS3  <= csS2;
    togS1 <= frameTog_r;
    togS2 <= togS1;
  end
  // a frame with no clock edge leaves the toggle alone and is dropped
  assign frameEnd = csS2 && !csS3 && (togS2 != togSeen_r); // [R09]

  always_ff @(posedge mclk)
  begin
    if (reset)
      togSeen_r <= 1'b0;
    else if (frameEnd)
      togSeen_r <= togS2;
  end

  // ************************************************************
  // command gate
  // ************************************************************
  logic [10:0] secLo;
  logic [10:0] secHi;
  logic [2:0]  need;
  logic        isMod;
  logic        hit;
  logic        ok;
  // full sector range of the command
  always_comb
  begin
    secLo = addr_r[22:12];
    secHi = addr_r[22:12];
    need  = `SFCP_NB_ERASE;
    isMod = 1'b1;
    case (opc_r)
      `SFCP_OP_PROG:   need = `SFCP_NB_PROG;
      `SFCP_OP_ERS4K:  ;
      `SFCP_OP_ERS32K:
      begin
        secLo = {addr_r[22:15], 3'b000};
        secHi = {addr_r[22:15], 3'b111};
      end
      `SFCP_OP_ERS64K:
      begin
        secLo = {addr_r[22:16], 4'h0};
        secHi = {addr_r[22:16], 4'hf};
      end
      `SFCP_OP_CHIP1, `SFCP_OP_CHIP2:
      begin
        secLo = 11'h000;
        secHi = `SFCP_SECT_LAST;
        need  = `SFCP_NB_ONE;
      end
      default: isMod = 1'b0;
    endcase
  end

  sfcp_protect sfcp_protect_i (
    .sec (sec_r),
    .tb  (tb_r),
    .bp  (bp_r),
    .cmp (cmp_r),
    .lo  (secLo),
    .hi  (secHi),
    .hit (hit)
  );

  // common gate: idle, byte boundary, write enabled
  assign ok = frameEnd && !busy_r && aligned_r && wel_r; // [R11] [R12]

  // array commands and busy
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      busy_r  <= 1'b0;
      opStart <= 1'b0;
      opCode  <= 8'h00;
      opAddr  <= 24'h0;
      opData  <= 8'h00;
    end
    else
    begin
      opStart <= 1'b0;
      if (ok && ((isMod && bytes_r >= need && !hit) || // [R15] [R02]
                 (opc_r == `SFCP_OP_WRSR && bytes_r >= `SFCP_NB_WRSR)))
      begin
        busy_r  <= 1'b1;
        opStart <= 1'b1;
        opCode  <= opc_r;
        opAddr  <= addr_r;
        opData  <= dat0_r;
      end
      else if (opDone)
        busy_r <= 1'b0;
    end
  end

  // write enable latch and status write
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wel_r <= 1'b0;
      {sec_r, tb_r, bp_r, cmp_r} <= 6'h00;
      qe_r  <= `SFCP_QE_RESET;
    end
    else if (frameEnd && !busy_r && aligned_r) // [R11] [R12]
    begin
      if (opc_r == `SFCP_OP_WREN)
        wel_r <= 1'b1;
      else if (opc_r == `SFCP_OP_WRDI || (wel_r && isMod && bytes_r >= need && !hit))
        wel_r <= 1'b0;
      if (wel_r && opc_r == `SFCP_OP_WRSR && bytes_r >= `SFCP_NB_WRSR)
      begin
        wel_r <= 1'b0;
        {sec_r, tb_r, bp_r} <= addr_r[22:18]; // first status byte lands in address byte 1
        if (bytes_r >= `SFCP_NB_WRSR + 3'd1)
        begin
          cmp_r <= addr_r[8 + `SFCP_SR2_CMP];
          qe_r  <= addr_r[8 + `SFCP_SR2_QE] | quad_r; // quad mode keeps it set
        end
      end
    end
  end

  // quad instruction mode entry and exit
  always_ff @(posedge mclk)
  begin
    if (reset)
      quad_r <= 1'b0;
    else if (frameEnd && !busy_r && aligned_r)
    begin
      if (opc_r == `SFCP_OP_QUADON && qe_r)
        quad_r <= 1'b1; // [R14]
      else if (opc_r == `SFCP_OP_QUADOFF && quad_r)
        quad_r <= 1'b0;
    end
  end

  // status outputs
  always_ff @(posedge mclk)
  begin
    busy     <= busy_r;
    quadMode <= quad_r;
  end
endmodule

/* File: rtl/sfcp_host.sv */
// host controller: wishbone registers in, flash frames out
`timescale 1ns/1ps
`include "sfcp_defines.svh"
module sfcp_host (
  // clock and reset
  input  logic        mclk,
  input  logic        reset,
  // wishbone slave
  input  logic        cyc_i,
  input  logic        stb_i,
  input  logic        we_i,
  input  logic [4:0]  adr_i,
  input  logic [3:0]  sel_i,
  input  logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic        ack_o,
  // link
  sfcp_link_if.host   link
);
  import sfcp_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [16:0] cmd_r;
  logic [23:0] addr_r;
  logic [15:0] wdat_r;
  logic [15:0] rdat_r;
  sfcp_hstate_type st_r;
  logic        wrEn;
  logic        go;
  // write lands at the edge where the master sees ack
  assign wrEn = cyc_i && stb_i && we_i && ack_o && (&sel_i);
  assign go   = wrEn && adr_i == `SFCP_REG_CTRL && dat_i[0] && st_r == HS_IDLE;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cmd_r  <= 17'h0;
      addr_r <= 24'h0;
      wdat_r <= 16'h0;
    end
    else if (wrEn)
      case (adr_i)
        `SFCP_REG_CMD:   cmd_r  <= dat_i[16:0];
        `SFCP_REG_ADDR:  addr_r <= dat_i[23:0];
        `SFCP_REG_WDATA: wdat_r <= dat_i[15:0];
        default: ;
      endcase
  end

  // one wait state, ack for one cycle; unmapped reads give zero
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end
    else
    begin
      ack_o <= cyc_i && stb_i && !ack_o;
      case (adr_i)
        `SFCP_REG_CMD:   dat_o <= {15'h0, cmd_r};
        `SFCP_REG_ADDR:  dat_o <= {8'h0, addr_r};
        `SFCP_REG_WDATA: dat_o <= {16'h0, wdat_r};
        `SFCP_REG_CTRL:  dat_o <= {31'h0, st_r != HS_IDLE};
        `SFCP_REG_RDATA: dat_o <= {16'h0, rdat_r};
        default:         dat_o <= 32'h0;
      endcase
    end
  end

  // ************************************************************
  // serial clock divider, free running
  // ************************************************************
  logic [2:0] div_r;
  logic       rise;
  logic       fall;
  assign rise = (div_r == `SFCP_SCLK_HALF - 3'd1) && !link.sclk;
  assign fall = (div_r == `SFCP_SCLK_HALF - 3'd1) && link.sclk;
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      div_r     <= 3'd0;
      link.sclk <= 1'b0;
    end
    else if (div_r == `SFCP_SCLK_HALF - 3'd1)
    begin
      div_r     <= 3'd0;
      link.sclk <= ~link.sclk;
    end
    else
      div_r <= div_r + 3'd1;
  end

  // ************************************************************
  // frame sequencer
  // ************************************************************
  logic [3:0]  ioS1;
  logic [3:0]  ioS2;
  logic        quad;
  logic [6:0]  wrBits;
  logic [6:0]  total;
  logic [6:0]  cnt_r;
  logic [3:0]  gap_r;
  logic [63:0] tx_r;
  logic [15:0] rx_r;
  logic [63:0] txNxt;
  assign quad   = cmd_r[`SFCP_CMD_QUAD];
  assign wrBits = 7'd8 + (cmd_r[`SFCP_CMD_HASADR] ? 7'd24 : 7'd0) + {2'b00, cmd_r[11:10], 3'b000};
  assign total  = wrBits + {2'b00, cmd_r[13:12], 3'b000} + {4'h0, cmd_r[16:14]};
  assign txNxt  = quad ? {tx_r[59:0], 4'h0} : {tx_r[62:0], 1'b0}; // [R07]

  // device lines sampled through two flops
  always_ff @(posedge mclk)
  begin
    ioS1 <= link.io;
    ioS2 <= ioS1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_r           <= HS_IDLE;
      link.csN       <= 1'b1;
      link.hostIoOe  <= 4'h0;
      link.hostIoOut <= 4'h0;
      cnt_r          <= 7'd0;
      gap_r          <= 4'd0;
      rdat_r         <= 16'h0;
    end
    else
      case (st_r)
        HS_IDLE:
          if (go)
          begin
            st_r  <= HS_ARM;
            cnt_r <= 7'd0;
            tx_r  <= cmd_r[`SFCP_CMD_HASADR] ? {cmd_r[7:0], addr_r, wdat_r, 16'h0} :
                                            {cmd_r[7:0], wdat_r, 40'h0};
          end
        HS_ARM:
          if (fall)
          begin
            link.csN       <= 1'b0; // [R03]
            link.hostIoOe  <= quad ? 4'hf : 4'h1;
            link.hostIoOut <= quad ? tx_r[63:60] : {3'b000, tx_r[63]}; // [R05]
            st_r           <= HS_SHIFT;
          end
        HS_SHIFT:
          if (rise)
          begin
            cnt_r <= cnt_r + (quad ? 7'd4 : 7'd1);
            rx_r  <= quad ? {rx_r[11:0], ioS2} : {rx_r[14:0], ioS2[1]};
          end
          else if (fall && cnt_r >= total)
          begin
            link.csN      <= 1'b1; // [R09]
            link.hostIoOe <= 4'h0;
            rdat_r        <= rx_r;
            gap_r         <= 4'd0;
            st_r          <= HS_GAP;
          end
          else if (fall)
          begin
            tx_r           <= txNxt;
            link.hostIoOe  <= (cnt_r < wrBits) ? (quad ? 4'hf : 4'h1) : 4'h0;
            link.hostIoOut <= quad ? txNxt[63:60] : {3'b000, txNxt[63]};
          end
        HS_GAP:
        begin
          gap_r <= gap_r + 4'd1;
          if (gap_r == `SFCP_CS_GAP - 4'd1)
            st_r <= HS_IDLE;
        end
        default: st_r <= HS_IDLE;
      endcase
  end
endmodule

/* File: sim/sfcp_link_props.sv */
// assertions on the flash link and the device array side
`timescale 1ns/1ps
module sfcp_link_props (
  // link signals
  input logic       csN,
  input logic       sclk,
  input logic [3:0] hostIoOut,
  input logic [3:0] devIoOe,
  // device array side
  input logic       mclk,
  input logic       reset,
  input logic       opStart,
  input logic       opDone,
  input logic       busy
);
  // ****************************************
  // link framing and device gating
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // frame ends with chip select going high
  sequence csUp;
    $rose(csN);
  endsequence
  // chip select moves only while the clock is low
  csFall_a: assert property ($fell(csN) |-> !sclk) else $error("cs fell with sclk high");
  csRise_a: assert property (csUp |-> !sclk) else $error("cs rose with sclk high");
  // gap keeps the device from merging two frames
  csGap_a: assert property (csUp |-> csN [*8]) else $error("cs gap too short");
  hostEdge_a: assert property (!csN && $changed(hostIoOut) |-> $fell(sclk))
    else $error("host line moved off falling sclk");
  startGap_a: assert property (opStart |-> csN && $past(csN, 2))
    else $error("start issued inside a frame");
  busyFree_a: assert property (opStart |-> !$past(busy)) else $error("start while busy");
  busySet_a: assert property (opStart |-> ##[0:1] busy) else $error("busy not raised");
  busyDone_a: assert property (opDone |-> ##[1:3] !busy) else $error("busy not cleared");
  oeDrop_a: assert property (csUp |-> ##[0:9] (devIoOe == 4'h0))
    else $error("device still drives after frame");
endmodule

/* File: sim/test_serial_flash_cmd_frame_protect.sv */
// self-checking bench: host and device joined over the flash link
`timescale 1ns/1ps
module test_serial_flash_cmd_frame_protect;
  import sfcp_pkg::*;
  // ****************************************
  // signals and instances
  // ****************************************
  logic          mclk = 1'b0;
  logic          reset = 1'b1;
  logic          cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, busy, quadMode, opStart;
  logic          opDone = 1'b0, qd = 1'b0;
  logic [4:0]    adr = 5'h00;
  logic [31:0]   datW = 32'h0, datR;
  logic [23:0]   opAddr;
  sfcp_byte_type opCode, opData, sr1;
  int            mismatches = 0, n_tests = 0, starts = 0, seed = 32'h4147b60b;
  sfcp_link_if link ();
  sfcp_host sfcp_host_i (.mclk(mclk), .reset(reset), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(datW), .dat_o(datR), .ack_o(ack), .link(link));
  sfcp_device sfcp_device_i (.link(link), .mclk(mclk), .reset(reset), .opStart(opStart),
    .opCode(opCode), .opAddr(opAddr), .opData(opData), .opDone(opDone), .busy(busy),
    .quadMode(quadMode));
  sfcp_link_props sfcp_link_props_i (.csN(link.csN), .sclk(link.sclk),
    .hostIoOut(link.hostIoOut), .devIoOe(link.devIoOe), .mclk(mclk), .reset(reset),
    .opStart(opStart), .opDone(opDone), .busy(busy));
  // 20 MHz clock
  always #25 mclk = ~mclk;
  // count accepted modify and status write commands
  always @(posedge mclk)
  begin
    if (opStart === 1'b1)
      starts++;
  end
  // ****************************************
  // tasks and expectations
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (e !== s)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  // classic wishbone cycle, waits for ack without assuming a latency
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datW <= d;
    do begin @(posedge mclk); n++; end while (ack !== 1'b1 && n < 50);
    q = datR;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge mclk);
  endtask
  // one link frame; tail bits make it end off a byte boundary
  task automatic frame(input logic [7:0] op, input logic a, input logic [1:0] nw, nr,
                       input logic [2:0] tl, input logic [23:0] ad, input logic [15:0] wd);
    logic [31:0] q;
    int          n;
    n = 0;
    wb(1'b1, 5'h04, {8'h0, ad}, q);
    wb(1'b1, 5'h08, {16'h0, wd}, q);
    wb(1'b1, 5'h00, {15'h0, tl, nr, nw, qd, a, op}, q);
    wb(1'b1, 5'h0c, 32'h1, q);
    do begin wb(1'b0, 5'h0c, 32'h0, q); n++; end while (q[0] !== 1'b0 && n < 400);
    if (n >= 400)
      chk("frame done", 1, 0);
    repeat (12) @(posedge mclk);
  endtask
  task automatic done();
    opDone <= 1'b1;
    @(posedge mclk);
    opDone <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic stat(input logic b);
    logic [31:0] q;
    frame(8'h05, 1'b0, 2'd0, 2'd1, 3'd0, 24'h0, 16'h0);
    wb(1'b0, 5'h10, 32'h0, q);
    chk("status", {1'b0, sr1[6:2], 1'b0, b}, {24'h0, q[7:0]});
  endtask
  // status write: first byte is the block-protect layout, second holds quad enable and invert
  task automatic setSr(input logic [7:0] s1, input logic [7:0] s2);
    int n0;
    n0 = starts;
    sr1 = s1;
    frame(8'h06, 1'b0, 2'd0, 2'd0, 3'd0, 24'h0, 16'h0);
    frame(8'h01, 1'b0, 2'd2, 2'd0, 3'd0, 24'h0, {s1, s2});
    chk("status write", 1, starts - n0);
    done();
  endtask
  // any protected 4KB sector between lo and hi
  function automatic logic hitFn(logic [7:0] s1, logic cmp, logic [10:0] lo, logic [10:0] hi);
    logic [2:0]  bp;
    logic [11:0] n;
    logic        h;
    bp = s1[4:2];
    h = 1'b0;
    n = s1[6] ? (bp >= 3'd4 ? 12'd8 : 12'd1 << (bp - 3'd1)) : 12'd32 << (bp - 3'd1);
    for (int s = 0; s < 2048; s++)
      if (s >= lo && s <= hi && (cmp ^ ((bp == 3'd7) ||
          (bp != 3'd0 && (s1[5] ? s < n : s >= 2048 - n)))))
        h = 1'b1;
    return h;
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog cuts a hung run short
  initial
  begin
    repeat (90000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] r, q;
    logic [7:0]  op, ops[6];
    logic [10:0] s, lo, hi;
    logic        a, e;
    int          n0;
    ops = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60, 8'h02};
    sr1 = 8'h00;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    repeat (20) @(posedge mclk);
    wb(1'b0, 5'h14, 32'h0, q);
    chk("unmapped", 0, q);
    // random protection settings against every modify opcode
    for (int i = 0; i < 18; i++)
    begin
      r = $random(seed);
      op = ops[i % 6];
      s = (i % 3 == 0) ? 11'h000 : (i % 3 == 1) ? 11'h7ff : r[26:16];
      a = !(op == 8'hc7 || op == 8'h60);
      lo = !a ? 11'h000 : op == 8'h52 ? s & 11'h7f8 : op == 8'hd8 ? s & 11'h7f0 : s;
      hi = !a ? 11'h7ff : op == 8'h52 ? s | 11'h007 : op == 8'hd8 ? s | 11'h00f : s;
      setSr({1'b0, r[6:2], 2'b00}, {1'b0, r[7], 6'h0});
      n0 = starts;
      frame(8'h06, 1'b0, 2'd0, 2'd0, 3'd0, 24'h0, 16'h0);
      frame(op, a, {1'b0, op == 8'h02}, 2'd0, 3'd3, {1'b0, s, 12'h0}, r[15:0]);
      chk("unaligned", 0, starts - n0);
      frame(op, a, {1'b0, op == 8'h02}, 2'd0, 3'd0, {1'b0, s, 12'h0}, r[15:0]);
      e = !hitFn(sr1, r[7], lo, hi);
      chk("accept", e, starts - n0);
      if (e)
      begin
        chk("code", op, opCode);
        if (a)
          chk("addr", {1'b0, s, 12'h0}, opAddr);
        if (op == 8'h02)
          chk("data", r[15:8], opData);
        done();
      end
    end
    // while busy only the status read is served
    setSr(8'h00, 8'h00);
    n0 = starts;
    frame(8'h06, 1'b0, 2'd0, 2'd0, 3'd0, 24'h0, 16'h0);
    frame(8'hd8, 1'b1, 2'd0, 2'd0, 3'd0, 24'h123000, 16'h0);
    stat(1'b1);
    frame(8'h06, 1'b0, 2'd0, 2'd0, 3'd0, 24'h0, 16'h0);
    frame(8'h20, 1'b1, 2'd0, 2'd0, 3'd0, 24'h001000, 16'h0);
    chk("busy ignore", 1, starts - n0);
    done();
    // read cut short mid-byte, then a normal read
    frame(8'h05, 1'b0, 2'd0, 2'd1, 3'd3, 24'h0, 16'h0);
    stat(1'b0);
    // quad entry refused without quad enable, then taken
    frame(8'h38, 1'b0, 2'd0, 2'd0, 3'd0, 24'h0, 16'h0);
    chk("quad refused", 0, quadMode);
    setSr(8'h00, 8'h02);
    frame(8'h38, 1'b0, 2'd0, 2'd0, 3'd0, 24'h0, 16'h0);
    chk("quad on", 1, quadMode);
    qd = 1'b1;
    stat(1'b0);
    n0 = starts;
    frame(8'h06, 1'b0, 2'd0, 2'd0, 3'd0, 24'h0, 16'h0);
    frame(8'h20, 1'b1, 2'd0, 2'd0, 3'd0, 24'h456000, 16'h0);
    chk("quad erase", 1, starts - n0);
    chk("quad addr", 24'h456000, opAddr);
    done();
    frame(8'hff, 1'b0, 2'd0, 2'd0, 3'd0, 24'h0, 16'h0);
    qd = 1'b0;
    chk("quad off", 0, quadMode);
    end_of_test();
  end
endmodule
